// ===== core/tstc_core.sv
// Timer slave-mode and trigger control with AXI4-Lite registers
`timescale 1ns/100ps
module tstc_core
  import tstc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chan0_input,
  input wire logic chan1_input,
  input wire logic chan0_filtered_input,
  input wire logic chan1_filtered_input,
  input wire logic chan0_both_edge_detect,
  input wire logic motor_control_timer_trig,
  input wire logic count_dir_down,
  output logic [CNT_W-1:0] count_value,
  output logic master_trigger_out,
  output logic update_event
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_MODE_CFG) || (a == OFS_TRIG_SRC) ||
           (a == OFS_RUN_CTRL) || (a == OFS_EVENT_GEN) ||
           (a == OFS_RELOAD) || (a == OFS_COUNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  tstc_wr_e wr_st_r;
  tstc_rd_e rd_st_r;
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_mux;
  logic wr_do;

  logic [31:0] mode_cfg_r;
  logic [3:0] trig_sel_r;
  logic tme_r;
  logic reload_buffer_enable_r;
  logic ug_pulse_r;
  logic [CNT_W-1:0] preload_r;
  logic [CNT_W-1:0] active_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] reload_new;
  logic ue_r;
  logic [3:0] dly_r;

  logic [2:0] slv_mode;
  logic sync_en;
  logic spm_en;
  logic wr_reload;
  logic wr_run;
  logic sti_raw;
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;
  logic sti_lvl;
  logic sti_rise;
  logic e0;
  logic e1;
  logic up0;
  logic up1;
  logic qstep;
  logic qdown;
  logic step_req;
  logic run_ok;
  logic step;
  logic dn;
  logic restart_ev;
  logic reinit;
  logic ovf_ev;
  logic ue;
  logic hw_start;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign s_axi_awready = !aw_full_r && (wr_st_r == TSTC_WR_IDLE);
  assign s_axi_wready = !w_full_r && (wr_st_r == TSTC_WR_IDLE);
  assign s_axi_bvalid = (wr_st_r == TSTC_WR_RESP);
  assign s_axi_bresp = bresp_r;
  assign wr_do = aw_full_r && w_full_r && (wr_st_r == TSTC_WR_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'h0;
      w_full_r <= 1'h0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'h1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_full_r <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'h1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_do) begin
        w_full_r <= 1'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_r <= TSTC_WR_IDLE;
      bresp_r <= RESP_OKAY;
    end else begin
      unique case (wr_st_r)
        TSTC_WR_IDLE: begin
          if (wr_do) begin
            wr_st_r <= TSTC_WR_RESP;
            bresp_r <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        TSTC_WR_RESP: begin
          if (s_axi_bready) begin
            wr_st_r <= TSTC_WR_IDLE;
          end
        end
        default: wr_st_r <= TSTC_WR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, data one cycle after the address
  assign s_axi_arready = (rd_st_r == TSTC_RD_IDLE);
  assign s_axi_rvalid = (rd_st_r == TSTC_RD_DATA);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      OFS_MODE_CFG: rd_mux = mode_cfg_r;
      OFS_TRIG_SRC: rd_mux = {28'h0, trig_sel_r};
      OFS_RUN_CTRL: rd_mux = {30'h0, reload_buffer_enable_r, tme_r};
      OFS_RELOAD: rd_mux = 32'(preload_r);
      OFS_COUNT: rd_mux = 32'(cnt_r);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_r <= TSTC_RD_IDLE;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      unique case (rd_st_r)
        TSTC_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_st_r <= TSTC_RD_DATA;
            rdata_r <= rd_mux;
            rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        TSTC_RD_DATA: begin
          if (s_axi_rready) begin
            rd_st_r <= TSTC_RD_IDLE;
          end
        end
        default: rd_st_r <= TSTC_RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  assign slv_mode = mode_cfg_r[MODE_SLV_LSB +: 3];
  assign sync_en = mode_cfg_r[MODE_SYNC_BIT];
  assign spm_en = mode_cfg_r[MODE_SPM_BIT];
  assign wr_reload = wr_do && (aw_addr_r == OFS_RELOAD);
  assign wr_run = wr_do && (aw_addr_r == OFS_RUN_CTRL) && w_strb_r[0];
  assign reload_new = CNT_W'(wmerge(32'(preload_r), w_data_r, w_strb_r));

  // The source is not locked while a slave mode runs; changing it then
  // may give a spurious edge, which is the programmer's hazard.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_cfg_r <= RST_MODE_CFG;
      trig_sel_r <= RST_TRIG_SRC;
      reload_buffer_enable_r <= RST_RELOAD_BUFFER_ENABLE;
      ug_pulse_r <= 1'h0;
    end else begin
      if (wr_do && aw_addr_r == OFS_MODE_CFG) begin
        mode_cfg_r <= wmerge(mode_cfg_r, w_data_r, w_strb_r) &
                      MODE_CFG_MASK;
      end
      if (wr_do && aw_addr_r == OFS_TRIG_SRC && w_strb_r[0]) begin
        trig_sel_r <= w_data_r[3:0];
      end
      if (wr_run) begin
        reload_buffer_enable_r <= w_data_r[RUN_RELOAD_BUFFER_ENABLE_BIT];
      end
      ug_pulse_r <= wr_do && (aw_addr_r == OFS_EVENT_GEN) &&
                    w_strb_r[0] && w_data_r[EVG_UG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger source selection
  always_comb begin
    unique case (trig_sel_r)
      TS_CH0F: sti_raw = chan0_filtered_input;
      TS_CH1F: sti_raw = chan1_filtered_input;
      TS_CH0BED: sti_raw = chan0_both_edge_detect;
      TS_INTERNAL_TRIGGER_0: sti_raw = 1'h0;
      TS_INTERNAL_TRIGGER_1: sti_raw = motor_control_timer_trig;
      TS_INTERNAL_TRIGGER_2: sti_raw = 1'h0;
      // unlisted codes act as soft trigger
      default: sti_raw = ug_pulse_r;
    endcase
  end

  tstc_edge #(
    .W(3)
  ) u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in({sti_raw, chan1_input, chan0_input}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign sti_lvl = lvl[2];
  assign sti_rise = rise[2];

  ////////////////////////////////////////////////////////////////////////
  // Quadrature decode, up when the leading channel moves first
  assign e0 = rise[0] | fall[0];
  assign e1 = rise[1] | fall[1];
  assign up0 = lvl[0] ^ lvl[1];
  assign up1 = ~(lvl[1] ^ lvl[0]);

  always_comb begin
    qstep = 1'h0;
    qdown = 1'h0;
    unique case (slv_mode)
      SM_QD1: begin
        qstep = e0;
        qdown = !up0;
      end
      SM_QD2: begin
        qstep = e1;
        qdown = !up1;
      end
      SM_QD3: begin
        qstep = e0 | e1;
        qdown = e0 ? !up0 : !up1;
      end
      default: begin
        qstep = 1'h0;
        qdown = 1'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave mode gating of the counter step
  always_comb begin
    unique case (slv_mode)
      SM_DISABLE: step_req = 1'h1;
      SM_QD1, SM_QD2, SM_QD3: step_req = qstep;
      SM_RESTART: step_req = 1'h1;
      SM_PAUSE: step_req = sti_lvl;
      SM_TRIGGER: step_req = 1'h1;
      SM_EXTCLK: step_req = sti_rise;
    endcase
  end

  // master start held back while slaves synchronise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_r <= 4'h0;
    end else if (!tme_r) begin
      dly_r <= 4'h0;
    end else if (dly_r != SYNC_DLY_CYC) begin
      dly_r <= dly_r + 4'h1;
    end
  end

  // no step while run enable clear
  assign run_ok = tme_r && (!sync_en || dly_r == SYNC_DLY_CYC);
  assign step = run_ok && step_req;
  assign dn = (slv_mode == SM_QD1 || slv_mode == SM_QD2 ||
               slv_mode == SM_QD3) ? qdown : count_dir_down;
  assign restart_ev = (slv_mode == SM_RESTART) && sti_rise;
  assign reinit = restart_ev || ug_pulse_r;
  assign ovf_ev = step && (dn ? (cnt_r == '0) : (cnt_r == active_r));
  assign ue = ovf_ev || reinit;
  assign hw_start = (slv_mode == SM_TRIGGER) && sti_rise;

  ////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (reinit) begin
      // zero or reload value by direction
      cnt_r <= dn ? active_r : '0;
    end else if (step) begin
      if (dn) begin
        cnt_r <= (cnt_r == '0) ? active_r : cnt_r - CNT_W'(1);
      end else begin
        cnt_r <= (cnt_r == active_r) ? '0 : cnt_r + CNT_W'(1);
      end
    end
  end

  // Reload buffering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preload_r <= '0;
      active_r <= '0;
    end else begin
      if (wr_reload) begin
        preload_r <= reload_new;
      end
      if (wr_reload && !reload_buffer_enable_r) begin
        active_r <= reload_new;
      end else if (ue) begin
        active_r <= preload_r;
      end
    end
  end

  // Run enable: hardware set wins over software or single-pulse clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tme_r <= RST_TME;
    end else begin
      if (wr_run) begin
        tme_r <= w_data_r[RUN_TME_BIT];
      end
      if (spm_en && ue) begin
        tme_r <= 1'h0;
      end
      if (hw_start) begin
        tme_r <= 1'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ue_r <= 1'h0;
    end else begin
      ue_r <= ue;
    end
  end

  assign count_value = cnt_r;
  assign master_trigger_out = tme_r;
  assign update_event = ue_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_idle_count:
    assert property (slv_mode == SM_DISABLE && run_ok && !reinit &&
                     !dn && cnt_r != active_r
                     |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("internal clock mode did not count");
  chk_quad_idle:
    assert property (slv_mode == SM_QD1 && !e0 && !reinit
                     |=> $stable(cnt_r))
    else $error("quadrature mode 1 counted without channel 0 edge");
  chk_restart_zero:
    assert property (restart_ev && !dn |=> cnt_r == '0)
    else $error("restart did not clear the counter");
  chk_pause_freeze:
    assert property (slv_mode == SM_PAUSE && !sti_lvl && !reinit
                     |=> $stable(cnt_r))
    else $error("pause mode moved while trigger low");
  chk_trig_start:
    assert property (hw_start |=> tme_r)
    else $error("trigger did not set run enable");
  chk_ext_clock:
    assert property (slv_mode == SM_EXTCLK && !sti_rise && !reinit
                     |=> $stable(cnt_r))
    else $error("external clock mode moved without edge");
  chk_sync_hold:
    assert property (sync_en && $rose(tme_r) |-> !run_ok ##1 !run_ok)
    else $error("master started before synchronisation delay");
  chk_buf_direct:
    assert property (wr_reload && !reload_buffer_enable_r |=> active_r == preload_r)
    else $error("unbuffered reload not applied at once");
  chk_buf_hold:
    assert property (wr_reload && reload_buffer_enable_r && !ue
                     |=> active_r == $past(active_r))
    else $error("buffered reload applied before update");
  chk_stop_off:
    assert property (!tme_r && !reinit |=> $stable(cnt_r))
    else $error("counter moved with run enable clear");
  chk_spm_stop:
    assert property (spm_en && ue && !hw_start |=> !tme_r)
    else $error("single pulse did not clear run enable");
  chk_src_default:
    assert property (trig_sel_r == 4'h3 |-> sti_raw == ug_pulse_r)
    else $error("reserved source not treated as soft trigger");

  cov_restart: cover property (restart_ev ##1 cnt_r == '0);
  cov_trig_run: cover property (hw_start ##1 tme_r ##1 step);
  cov_quad3: cover property (slv_mode == SM_QD3 && qstep && qdown);
  cov_spm: cover property (spm_en && ovf_ev ##1 !tme_r);
endmodule

// ===== core/tstc_edge.sv
// Registered sampler with rise and fall detection
`timescale 1ns/100ps
module tstc_edge #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] sig_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] cur_r;
  logic [W-1:0] prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_r <= '0;
      prev_r <= '0;
    end else begin
      cur_r <= sig_in;
      prev_r <= cur_r;
    end
  end

  assign level = cur_r;
  assign rise = cur_r & ~prev_r;
  assign fall = ~cur_r & prev_r;
endmodule

// ===== shared/tstc_pkg.sv
// Constants and types shared by the timer slave/trigger control block
package tstc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE_CFG = 8'h04;
  localparam logic [7:0] OFS_TRIG_SRC = 8'h08;
  localparam logic [7:0] OFS_RUN_CTRL = 8'h10;
  localparam logic [7:0] OFS_EVENT_GEN = 8'h30;
  localparam logic [7:0] OFS_RELOAD = 8'h34;
  localparam logic [7:0] OFS_COUNT = 8'h38;

  // Field positions
  localparam int MODE_SYNC_BIT = 0;
  localparam int MODE_SLV_LSB = 8;
  localparam int MODE_SPM_BIT = 24;
  localparam int RUN_TME_BIT = 0;
  localparam int RUN_RELOAD_BUFFER_ENABLE_BIT = 1;
  localparam int EVG_UG_BIT = 0;
  localparam logic [31:0] MODE_CFG_MASK = 32'h0100_0701;

  // Values after reset
  localparam logic [31:0] RST_MODE_CFG = 32'h0000_0000;
  localparam logic [3:0] RST_TRIG_SRC = 4'h0;
  localparam logic RST_TME = 1'h0;
  localparam logic RST_RELOAD_BUFFER_ENABLE = 1'h0;

  // Slave mode codes
  localparam logic [2:0] SM_DISABLE = 3'h0;
  localparam logic [2:0] SM_QD1 = 3'h1;
  localparam logic [2:0] SM_QD2 = 3'h2;
  localparam logic [2:0] SM_QD3 = 3'h3;
  localparam logic [2:0] SM_RESTART = 3'h4;
  localparam logic [2:0] SM_PAUSE = 3'h5;
  localparam logic [2:0] SM_TRIGGER = 3'h6;
  localparam logic [2:0] SM_EXTCLK = 3'h7;

  // Trigger source codes
  localparam logic [3:0] TS_SOFT = 4'h0;
  localparam logic [3:0] TS_CH0F = 4'h1;
  localparam logic [3:0] TS_CH1F = 4'h2;
  localparam logic [3:0] TS_CH0BED = 4'h8;
  localparam logic [3:0] TS_INTERNAL_TRIGGER_0 = 4'h9;
  localparam logic [3:0] TS_INTERNAL_TRIGGER_1 = 4'ha;
  localparam logic [3:0] TS_INTERNAL_TRIGGER_2 = 4'hb;

  // Master synchronisation delay
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_DLY_NS = 20;
  localparam logic [3:0] SYNC_DLY_CYC =
    4'((SYNC_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TSTC_WR_IDLE = 2'h1,
    TSTC_WR_RESP = 2'h2
  } tstc_wr_e;

  typedef enum logic [1:0] {
    TSTC_RD_IDLE = 2'h1,
    TSTC_RD_DATA = 2'h2
  } tstc_rd_e;
endpackage

// ===== verification/tb_timer_slave_trigger_control.sv
// Self-checking bench for the timer slave and trigger control
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_timer_slave_trigger_control import tstc_pkg::*;;
  localparam int CW = 16;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0] rsp;
  } tstc_row_s;
  tstc_row_s rows [8] = '{
    '{OFS_MODE_CFG, 32'hffffffff, MODE_CFG_MASK, RESP_OKAY},
    '{OFS_TRIG_SRC, 32'hffffffff, 32'h0000000f, RESP_OKAY},
    '{OFS_RUN_CTRL, 32'hfffffffc, 32'h0, RESP_OKAY},
    '{OFS_RUN_CTRL, 32'h2, 32'h2, RESP_OKAY},
    '{OFS_RELOAD, 32'hffff1234, 32'h1234, RESP_OKAY},
    '{OFS_COUNT, 32'h12345678, 32'h0, RESP_OKAY},
    '{8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR},
    '{OFS_EVENT_GEN, 32'h0, 32'h0, RESP_OKAY}};
  // Source, stimulus kind, restart expected
  logic [6:0] rtab [10] = '{{4'h0, 2'h0, 1'h1}, {4'h1, 2'h1, 1'h1},
    {4'h2, 2'h2, 1'h1}, {4'h2, 2'h1, 1'h0}, {4'h8, 2'h1, 1'h1},
    {4'h9, 2'h3, 1'h0}, {4'ha, 2'h3, 1'h1}, {4'hb, 2'h3, 1'h0},
    {4'h1, 2'h3, 1'h0}, {4'h3, 2'h3, 1'h0}};
  logic [7:0] radr [3] = '{OFS_MODE_CFG, OFS_TRIG_SRC, OFS_RUN_CTRL};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
  logic chan0_input, chan1_input, chan0_filtered_input;
  logic chan1_filtered_input, chan0_both_edge_detect;
  logic motor_control_timer_trig, master_trigger_out, update_event;
  logic count_dir_down = 1'b0;
  logic [CW-1:0] count_value, snap, p, v0;
  logic step_req = 1'b0, step_rev = 1'b0, mct_req = 1'b0;
  logic aw_hs = 1'b0, w_hs = 1'b0, b_hs = 1'b0, ar_hs = 1'b0, r_hs = 1'b0;
  int num_errors = 0, n_compared = 0;

  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  // Handshakes latched at the edge so tasks never race the design
  always @(posedge aclk) begin
    aw_hs <= s_axi_awvalid && s_axi_awready;
    w_hs <= s_axi_wvalid && s_axi_wready;
    b_hs <= s_axi_bvalid && s_axi_bready;
    ar_hs <= s_axi_arvalid && s_axi_arready;
    r_hs <= s_axi_rvalid && s_axi_rready;
    bresp_q <= s_axi_bresp;
    rresp_q <= s_axi_rresp;
    rd_q <= s_axi_rdata;
  end

  tstc_core #(.CNT_W(CW)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .chan0_input, .chan1_input, .chan0_filtered_input,
    .chan1_filtered_input, .chan0_both_edge_detect,
    .motor_control_timer_trig, .count_dir_down, .count_value,
    .master_trigger_out, .update_event);
  tstc_far_model far_u (.aclk, .aresetn, .step_req, .step_rev, .mct_req,
    .chan0_input, .chan1_input, .chan0_filtered_input,
    .chan1_filtered_input, .chan0_both_edge_detect,
    .motor_control_timer_trig);

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic hang(input logic ok);
    if (!ok) begin
      num_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      conclude();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge aclk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      cyc(1);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      n++;
    end while (!b_hs && n < 50);
    // Ready stays high between calls so no edge sees a double drive
    hang(b_hs);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      cyc(1);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      n++;
    end while (!r_hs && n < 50);
    hang(r_hs);
  endtask
  // Slave mode is parked at zero while the source changes
  // source change parked
  task automatic cfg(input logic [31:0] m, input logic [3:0] s,
                     input logic [31:0] r);
    wr(OFS_MODE_CFG, 32'h0);
    wr(OFS_TRIG_SRC, {28'h0, s});
    wr(OFS_RUN_CTRL, r);
    wr(OFS_MODE_CFG, m);
  endtask
  function automatic logic [31:0] sm(input logic [2:0] c);
    return {21'h0, c, 8'h0};
  endfunction
  task automatic step(input logic rev);
    step_req <= 1'b1;
    step_rev <= rev;
    cyc(1);
    step_req <= 1'b0;
    cyc(3);
  endtask
  task automatic pulse();
    mct_req <= 1'b1;
    cyc(1);
    mct_req <= 1'b0;
    cyc(4);
  endtask
  task automatic stim(input logic [1:0] k, input logic rev);
    case (k)
      2'h0: if (!rev) wr(OFS_EVENT_GEN, 32'h1);
      2'h3: if (!rev) pulse();
      default: repeat (k) step(rev);
    endcase
  endtask
  // Highest value before the counter falls back
  task automatic peak(output logic [CW-1:0] pk);
    logic [CW-1:0] last;
    int n;
    last = count_value;
    for (n = 0; n < 300; n++) begin
      cyc(1);
      if (count_value < last) break;
      last = count_value;
    end
    pk = last;
    hang(n < 300);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    aresetn <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd);
      `CHK(bresp_q, rows[i].rsp)
      rd(rows[i].a);
      `CHK(rd_q, rows[i].rd)
      `CHK(rresp_q, rows[i].rsp)
    end
    $display("test registers done");
    aresetn <= 1'b0;
    cyc(16);
    aresetn <= 1'b1;
    cyc(1);
    `CHK(master_trigger_out, 1'b0)
    foreach (radr[i]) begin
      rd(radr[i]);
      `CHK(rd_q, 32'h0)
    end
    $display("test reset done");
    wr(OFS_RELOAD, 32'hffff);
    foreach (rtab[i]) begin
      cfg(32'h0, rtab[i][6:3], 32'h1);
      cyc(5);
      wr(OFS_RUN_CTRL, 32'h0);
      snap = count_value;
      wr(OFS_MODE_CFG, sm(SM_RESTART));
      stim(rtab[i][2:1], 1'b0);
      cyc(6);
      `CHK(count_value, rtab[i][0] ? 16'h0 : snap)
      wr(OFS_MODE_CFG, 32'h0);
      stim(rtab[i][2:1], 1'b1);
    end
    $display("test restart done");
    cfg(sm(SM_RESTART), 4'ha, 32'h0);
    count_dir_down <= 1'b1;
    pulse();
    `CHK(count_value, 16'hffff)
    count_dir_down <= 1'b0;
    $display("test restart down done");
    for (int m = 1; m < 4; m++) begin
      cfg(sm(3'(m)), 4'h0, 32'h1);
      snap = count_value;
      repeat (4) step(1'b0);
      `CHK(count_value, snap + (m == 3 ? 16'h4 : 16'h2))
      repeat (4) step(1'b1);
      `CHK(count_value, snap)
    end
    $display("test quadrature done");
    cfg(sm(SM_PAUSE), 4'ha, 32'h1);
    snap = count_value;
    cyc(8);
    `CHK(count_value, snap)
    mct_req <= 1'b1;
    cyc(10);
    `CHK(count_value > snap, 1'b1)
    mct_req <= 1'b0;
    cyc(5);
    snap = count_value;
    cyc(8);
    `CHK(count_value, snap)
    $display("test pause done");
    cfg(sm(SM_TRIGGER), 4'ha, 32'h0);
    snap = count_value;
    cyc(5);
    `CHK(count_value, snap)
    pulse();
    rd(OFS_RUN_CTRL);
    `CHK(rd_q[0], 1'b1)
    `CHK(count_value > snap, 1'b1)
    cfg(sm(SM_EXTCLK), 4'ha, 32'h1);
    snap = count_value;
    repeat (3) pulse();
    cyc(2);
    `CHK(count_value, snap + 16'h3)
    $display("test trigger done");
    wr(OFS_RUN_CTRL, 32'h0);
    wr(OFS_RELOAD, 32'h20);
    cfg(32'h0, 4'h0, 32'h1);
    wr(OFS_EVENT_GEN, 32'h1);
    peak(p);
    `CHK(p, 16'h20)
    wr(OFS_RUN_CTRL, 32'h3);
    wr(OFS_RELOAD, 32'h40);
    peak(p);
    `CHK(p, 16'h20)
    peak(p);
    `CHK(p, 16'h40)
    wr(OFS_RUN_CTRL, 32'h0);
    cfg(32'h0100_0000, 4'h0, 32'h1);
    peak(p);
    cyc(3);
    `CHK(master_trigger_out, 1'b0)
    snap = count_value;
    cyc(5);
    `CHK(count_value, snap)
    $display("test reload done");
    for (int s = 0; s < 2; s++) begin
      cfg(32'(s), 4'h0, 32'h0);
      wr(OFS_EVENT_GEN, 32'h1);
      `CHK(update_event, 1'b1)
      cyc(4);
      `CHK(update_event, 1'b0)
      wr(OFS_RUN_CTRL, 32'h1);
      `CHK(master_trigger_out, 1'b1)
      cyc(4);
      if (s == 0) v0 = count_value;
      else `CHK(count_value, v0 - 16'h2)
    end
    $display("test sync done");
    conclude();
  end
endmodule

// ===== verification/tstc_far_model.sv
// Far-side model: channel pins and companion timer trigger
`timescale 1ns/100ps
module tstc_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_req,
  input wire logic step_rev,
  input wire logic mct_req,
  output logic chan0_input,
  output logic chan1_input,
  output logic chan0_filtered_input,
  output logic chan1_filtered_input,
  output logic chan0_both_edge_detect,
  output logic motor_control_timer_trig
);
  logic [1:0] phase_r;
  ////////////////////////////////////////////////////////////////
  // Gray steps: one channel moves per step, like a real encoder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= 2'h0;
    end else if (step_req) begin
      phase_r <= step_rev ? phase_r - 2'h1 : phase_r + 2'h1;
    end
  end
  assign chan0_input = phase_r[1] ^ phase_r[0];
  assign chan1_input = phase_r[1];
  // Filter stands in as one cycle of delay
  always_ff @(posedge aclk) begin
    chan0_filtered_input <= chan0_input;
    chan1_filtered_input <= chan1_input;
    chan0_both_edge_detect <= chan0_input ^ chan0_filtered_input;
    motor_control_timer_trig <= mct_req;
  end
endmodule
